/* pkg/adcsc_pkg.sv */
package adcsc_pkg;

  // Register addresses
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_ONE  = 5'h01;
  localparam logic [4:0] ADDR_CONTROL_TWO  = 5'h02;
  localparam logic [4:0] ADDR_CONTROL_THREE  = 5'h03;
  localparam logic [4:0] ADDR_PINCTL = 5'h04;
  localparam logic [4:0] ADDR_DELAY  = 5'h05;
  localparam logic [4:0] ADDR_CMAP_U = 5'h06;
  localparam logic [4:0] ADDR_CMAP_L = 5'h07;
  localparam logic [4:0] ADDR_SEQCFG = 5'h08;
  localparam logic [4:0] ADDR_OUTDIR = 5'h09;
  localparam logic [4:0] ADDR_SOCAL  = 5'h0a;
  localparam logic [4:0] ADDR_SGCAL  = 5'h0b;
  localparam logic [4:0] ADDR_HOLE   = 5'h0c;
  localparam logic [4:0] ADDR_SCGCAL = 5'h0d;
  localparam logic [4:0] ADDR_RESULT_WORD_0  = 5'h0e;
  localparam logic [4:0] ADDR_RESULT_WORD_3  = 5'h11;

  // Writable register storage
  localparam int unsigned NUM_RW     = 12;
  localparam logic [3:0]  RW_IDX_SCG = 4'hb;
  localparam logic [1:0]  BYTES_ONE  = 2'h1;
  localparam logic [1:0]  BYTES_TWO  = 2'h2;
  localparam logic [1:0]  BYTES_WORD = 2'h3;
  localparam logic [23:0] REG_RESET  = 24'h000000;

  // Command byte fields
  localparam int unsigned CMD_START  = 7;
  localparam int unsigned CMD_FMT    = 6;
  localparam int unsigned CMD_MODE_L = 4;
  localparam int unsigned CMD_RATE_L = 0;
  localparam int unsigned CMD_ADDR_L = 1;
  localparam int unsigned CMD_RD     = 0;
  localparam logic [1:0]  MODE_CAL   = 2'h2;
  localparam logic [1:0]  MODE_SEQ   = 2'h3;

  // Power states
  localparam logic [1:0]  PWR_CONV   = 2'h0;
  localparam logic [1:0]  PWR_SLEEP  = 2'h1;
  localparam logic [1:0]  PWR_STBY   = 2'h2;

  // Status word bit positions
  localparam int unsigned ST_RDY     = 0;
  localparam int unsigned ST_BUSY    = 1;
  localparam int unsigned ST_PWR_L   = 2;
  localparam int unsigned ST_RATE_L  = 4;
  localparam int unsigned ST_AOR     = 8;
  localparam int unsigned ST_DOR     = 9;
  localparam int unsigned ST_SGOR    = 10;
  localparam int unsigned ST_ERR     = 11;
  localparam int unsigned ST_GPOC    = 12;
  localparam int unsigned ST_ORDF    = 13;
  localparam int unsigned ST_REF     = 14;
  localparam int unsigned ST_SCANF   = 15;
  localparam int unsigned ST_SRDY_L  = 16;
  localparam int unsigned ST_INRST   = 22;

  // Per-channel byte inside the channel map registers
  localparam int unsigned NUM_CH     = 6;
  localparam int unsigned CH_PER_MAP = 3;
  localparam int unsigned CHF_W      = 8;
  localparam int unsigned CHF_GPO_EN = 0;
  localparam int unsigned CHF_GPO_L  = 1;
  localparam int unsigned CHF_EN     = 3;
  localparam int unsigned CHF_ORD_L  = 4;
  localparam logic [2:0]  ORD_BAD_LO = 3'h0;
  localparam logic [2:0]  ORD_BAD_HI = 3'h7;
  localparam int unsigned SEQF_MODE_L = 2;

  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_WRITE, PH_READ} adcsc_phase_e;

  // Levels and events coming from the converter core
  typedef struct packed {
    logic             conv_done;
    logic [2:0]       conv_ch;
    logic             mod_busy;
    logic [1:0]       pwr_state;
    logic             ain_over;
    logic             dout_over;
    logic             ref_ok;
    logic             in_reset;
    logic             cfg_bad;
    logic [3:0][23:0] result;
  } adcsc_core_s;

  typedef struct packed {
    adcsc_phase_e          phase;
    logic [4:0]            addr;
    logic [1:0]            bytes_left;
    logic [23:0]           accum;
    logic [23:0]           rd_shift;
    logic [7:0]            rd_byte;
    logic                  rd_valid;
    logic                  rdy;
    logic [5:0]            srdy;
    logic [3:0]            last_rate;
    logic                  scan_fault;
    logic [NUM_RW-1:0][23:0] regs;
    logic                  conv_req;
    logic [3:0]            conv_rate;
    logic [1:0]            conv_mode;
    logic                  wr_pulse;
    logic [23:0]           status;
  } adcsc_state_s;

endpackage

/* design/adcsc_top.sv */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE1: Each transaction opens with a command byte, conversion or register access layout.
// RULE2: Conversion layout low four bits give the rate code for that conversion.
// RULE3: Conversion layout bits five..four: 10 requests calibration, 11 requests sequencing.
// RULE4: Host keeps bit six low for conversion commands.
// RULE5: Host sets bit seven of every command byte.
// RULE6: Status bit 0 shows a fresh result is ready.
// RULE7: Status bit 1 shows the modulator is busy measuring.
// RULE8: Status bits 3..2 give power state: 00 converting, 01 sleep, 10 standby.
// RULE9: Status bits 7..4 give rate code of last finished conversion.
// RULE10: Status bit 8 flags input above reference.
// RULE11: Status bit 9 flags result out of representable range.
// RULE12: Status bit 10 flags system gain calibration out of range.
// RULE13: Status bit 11 flags an invalid configuration combination.
// RULE14: Status bit 12 flags two channels driving the same output.
// RULE15: Status bit 13 flags shared sequence positions or position code 000/111.
// RULE16: Status bit 14 shows reference present, forced low in sleep or standby.
// RULE17: Status bit 15 flags scan with no channels or calibration invalid for scanning.
// RULE18: Status bits 21..16 are per-channel ready flags set by that channel.
// RULE19: Status bit 22 shows converter in reset; bit 23 reserved reads zero.
// RULE20: Status and result registers are read-only; writes change nothing.
// RULE21: Address 0x0c reads zero and ignores writes.
module adcsc_top #(
  parameter logic [23:0] SGC_MAX = 24'h7fffff  // Largest legal system gain value
) (
  input  wire logic                   CORE_CLK_I,       // 40 MHz clock
  input  wire logic                   RESETN_I,         // Synchronous reset, active low
  input  wire logic                   TXN_START_I,      // Bus transaction start pulse
  input  wire logic                   BYTE_VALID_I,     // Written byte strobe
  input  wire logic [7:0]             BYTE_I,           // Written byte
  input  wire logic                   RD_BYTE_REQ_I,    // Request next read byte
  input  wire adcsc_pkg::adcsc_core_s CORE_I,           // Converter core levels
  output logic [7:0]                  RD_BYTE_O,        // Read byte
  output logic                        RD_BYTE_VALID_O,  // Read byte valid pulse
  output logic                        CONV_REQ_O,       // Conversion command pulse
  output logic [3:0]                  CONV_RATE_O,      // Requested rate code
  output logic [1:0]                  CONV_MODE_O,      // Requested operation
  output logic                        REG_WR_O,         // Register committed pulse
  output logic [4:0]                  REG_WR_ADDR_O,    // Address of committed write
  output logic [23:0]                 REG_WR_DATA_O,    // Value of committed write
  output logic [23:0]                 STATUS_O          // Live status word
);
  import adcsc_pkg::*;

  adcsc_state_s s_r;
  adcsc_state_s s_nxt;

  // Writable register check, shared by read and write paths
  function automatic logic is_rw(input logic [4:0] a);
    is_rw = ((a >= ADDR_CONTROL_ONE) && (a <= ADDR_SGCAL)) || (a == ADDR_SCGCAL);
  endfunction

  // Storage slot of a writable register
  function automatic logic [3:0] rw_idx(input logic [4:0] a);
    rw_idx = (a == ADDR_SCGCAL) ? RW_IDX_SCG : 4'(a - ADDR_CONTROL_ONE);
  endfunction

  // Bytes moved for an address; zero for the hole and beyond the map
  function automatic logic [1:0] reg_bytes(input logic [4:0] a);
    if (a == ADDR_HOLE || a > ADDR_RESULT_WORD_3) begin
      reg_bytes = 2'h0;
    end else if (a == ADDR_DELAY) begin
      reg_bytes = BYTES_TWO;
    end else if ((a >= ADDR_CONTROL_ONE && a <= ADDR_PINCTL) || a == ADDR_SEQCFG ||
                 a == ADDR_OUTDIR) begin
      reg_bytes = BYTES_ONE;
    end else begin
      reg_bytes = BYTES_WORD;
    end
  endfunction

  // Byte of one channel from the two channel map words
  function automatic logic [7:0] chan_field(input adcsc_state_s st, input int unsigned ch);
    logic [23:0] map;
    map = (ch < CH_PER_MAP) ? st.regs[rw_idx(ADDR_CMAP_L)] : st.regs[rw_idx(ADDR_CMAP_U)];
    chan_field = map[(ch % CH_PER_MAP)*CHF_W +: CHF_W];
  endfunction

  // Channel map checks, recomputed every cycle from stored settings
  logic       gpo_conflict;
  logic       order_fault;
  logic       any_enabled;
  logic [7:0] fi;
  logic [7:0] fj;

  always_comb begin
    gpo_conflict = 1'b0;
    order_fault  = 1'b0;
    any_enabled  = 1'b0;
    fi           = 8'h00;
    fj           = 8'h00;
    for (int unsigned i = 0; i < NUM_CH; i++) begin
      fi = chan_field(s_r, i);
      if (fi[CHF_EN]) begin
        any_enabled = 1'b1;
        // Only enabled channels take part in the sequence
        if (fi[CHF_ORD_L +: 3] == ORD_BAD_LO || fi[CHF_ORD_L +: 3] == ORD_BAD_HI) begin
          order_fault = 1'b1;  // [RULE15]
        end
      end
      for (int unsigned j = i + 1; j < NUM_CH; j++) begin
        fj = chan_field(s_r, j);
        if (fi[CHF_GPO_EN] && fj[CHF_GPO_EN] &&
            fi[CHF_GPO_L +: 2] == fj[CHF_GPO_L +: 2]) begin
          gpo_conflict = 1'b1;  // [RULE14]
        end
        if (fi[CHF_EN] && fj[CHF_EN] && fi[CHF_ORD_L +: 3] == fj[CHF_ORD_L +: 3]) begin
          order_fault = 1'b1;  // [RULE15]
        end
      end
    end
  end

  // Status word assembled from core levels and own flags
  logic [23:0] status_now;
  logic [23:0] rd_value;
  logic [4:0]  cmd_addr;
  logic [23:0] wr_word;
  logic [23:0] seq_cfg;

  always_comb begin
    status_now                  = 24'h000000;  // Reserved bit 23 stays zero [RULE19]
    status_now[ST_RDY]          = s_r.rdy;  // [RULE6]
    status_now[ST_BUSY]         = CORE_I.mod_busy;  // [RULE7]
    status_now[ST_PWR_L +: 2]   = CORE_I.pwr_state;  // [RULE8]
    status_now[ST_RATE_L +: 4]  = s_r.last_rate;  // [RULE9]
    status_now[ST_AOR]          = CORE_I.ain_over;  // [RULE10]
    status_now[ST_DOR]          = CORE_I.dout_over;  // [RULE11]
    status_now[ST_SGOR]         = s_r.regs[rw_idx(ADDR_SGCAL)] > SGC_MAX;  // [RULE12]
    status_now[ST_ERR]          = CORE_I.cfg_bad;  // [RULE13]
    status_now[ST_GPOC]         = gpo_conflict;  // [RULE14]
    status_now[ST_ORDF]         = order_fault;  // [RULE15]
    status_now[ST_REF]          = CORE_I.ref_ok && (CORE_I.pwr_state == PWR_CONV);  // [RULE16]
    status_now[ST_SCANF]        = s_r.scan_fault;  // [RULE17]
    status_now[ST_SRDY_L +: 6]  = s_r.srdy;  // [RULE18]
    status_now[ST_INRST]        = CORE_I.in_reset;  // [RULE19]
  end

  // Read value of the addressed register, left aligned for MSB-first shifting
  always_comb begin
    cmd_addr = BYTE_I[CMD_ADDR_L +: 5];
    rd_value = 24'h000000;  // Hole and beyond the map read zero [RULE21]
    if (cmd_addr == ADDR_STATUS) begin
      rd_value = status_now;
    end else if (is_rw(cmd_addr)) begin
      rd_value = s_r.regs[rw_idx(cmd_addr)];
    end else if (cmd_addr >= ADDR_RESULT_WORD_0 && cmd_addr <= ADDR_RESULT_WORD_3) begin
      rd_value = CORE_I.result[2'(cmd_addr - ADDR_RESULT_WORD_0)];
    end
    case (reg_bytes(cmd_addr))
      BYTES_ONE: rd_value = {rd_value[7:0], 16'h0000};
      BYTES_TWO: rd_value = {rd_value[15:0], 8'h00};
      default:   rd_value = rd_value;
    endcase
    wr_word = {s_r.accum[15:0], BYTE_I};
    seq_cfg = s_r.regs[rw_idx(ADDR_SEQCFG)];
  end

  // Next-state logic for the whole block
  always_comb begin
    s_nxt          = s_r;
    s_nxt.conv_req = 1'b0;
    s_nxt.wr_pulse = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.status   = status_now;

    if (TXN_START_I) begin
      s_nxt.phase = PH_CMD;  // First byte of every transaction is a command [RULE1]
    end else if (BYTE_VALID_I) begin
      case (s_r.phase)
        PH_CMD: begin
          if (!BYTE_I[CMD_START]) begin
            s_nxt.phase = PH_IDLE;  // Command without start bit is dropped [RULE5]
          end else if (!BYTE_I[CMD_FMT]) begin
            // Conversion layout [RULE1] [RULE4]
            s_nxt.conv_req  = 1'b1;
            s_nxt.conv_rate = BYTE_I[CMD_RATE_L +: 4];  // [RULE2]
            s_nxt.conv_mode = BYTE_I[CMD_MODE_L +: 2];  // [RULE3]
            // Calibration while any sequencer mode is selected still pulses conv_req but raises the scan fault [RULE17]
            s_nxt.scan_fault =
              (BYTE_I[CMD_MODE_L +: 2] == MODE_SEQ && !any_enabled) ||
              (BYTE_I[CMD_MODE_L +: 2] == MODE_CAL && seq_cfg[SEQF_MODE_L +: 2] != 2'h0);
            s_nxt.phase = PH_IDLE;
          end else begin
            s_nxt.addr       = cmd_addr;
            s_nxt.bytes_left = reg_bytes(cmd_addr);
            s_nxt.accum      = 24'h000000;
            if (BYTE_I[CMD_RD]) begin
              s_nxt.rd_shift = rd_value;
              s_nxt.phase    = PH_READ;
              if (cmd_addr == ADDR_STATUS) begin
                // Reading status consumes the ready flags
                s_nxt.rdy  = 1'b0;
                s_nxt.srdy = 6'h00;
              end
            end else begin
              s_nxt.phase = PH_WRITE;
            end
          end
        end
        PH_WRITE: begin
          // Data bytes arrive MSB first; extra bytes fall away
          if (s_r.bytes_left != 2'h0) begin
            s_nxt.accum      = wr_word;
            s_nxt.bytes_left = s_r.bytes_left - 2'h1;
            if (s_r.bytes_left == 2'h1 && is_rw(s_r.addr)) begin
              // Read-only, hole and unmapped addresses never commit [RULE20] [RULE21]
              s_nxt.regs[rw_idx(s_r.addr)] = wr_word;
              s_nxt.wr_pulse = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.phase = s_r.phase;
        end
      endcase
    end else if (RD_BYTE_REQ_I && s_r.phase == PH_READ) begin
      // Past the register width the block answers zero
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_byte  = (s_r.bytes_left != 2'h0) ? s_r.rd_shift[23:16] : 8'h00;
      s_nxt.rd_shift = {s_r.rd_shift[15:0], 8'h00};
      if (s_r.bytes_left != 2'h0) begin
        s_nxt.bytes_left = s_r.bytes_left - 2'h1;
      end
    end

    // Core events come last so a set beats a same-cycle clear
    if (CORE_I.conv_done) begin
      s_nxt.rdy       = 1'b1;  // [RULE6]
      s_nxt.last_rate = s_r.conv_rate;  // [RULE9]
      if (CORE_I.conv_ch < 3'(NUM_CH)) begin
        s_nxt.srdy[CORE_I.conv_ch] = 1'b1;  // [RULE18]
      end
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign RD_BYTE_O       = s_r.rd_byte;
  assign RD_BYTE_VALID_O = s_r.rd_valid;
  assign CONV_REQ_O      = s_r.conv_req;
  assign CONV_RATE_O     = s_r.conv_rate;
  assign CONV_MODE_O     = s_r.conv_mode;
  assign REG_WR_O        = s_r.wr_pulse;
  assign REG_WR_ADDR_O   = s_r.addr;
  assign REG_WR_DATA_O   = s_r.accum;
  assign STATUS_O        = s_r.status;

endmodule

`default_nettype wire

/* bench/adcsc_checker.sv */
`timescale 1ns/10ps
`default_nettype none

// Port-level watcher; one clock domain, so one default clocking
module adcsc_checker
  import adcsc_pkg::*;
(
  input wire logic                   CORE_CLK_I,      // Clock
  input wire logic                   RESETN_I,        // Reset
  input wire logic                   TXN_START_I,     // Frame start
  input wire logic                   BYTE_VALID_I,    // Byte strobe
  input wire logic [7:0]             BYTE_I,          // Byte
  input wire logic                   RD_BYTE_REQ_I,   // Read pull
  input wire adcsc_pkg::adcsc_core_s CORE_I,          // Core levels
  input wire logic                   RD_BYTE_VALID_O, // Read valid
  input wire logic                   CONV_REQ_O,      // Conversion pulse
  input wire logic [3:0]             CONV_RATE_O,     // Rate code
  input wire logic [1:0]             CONV_MODE_O,     // Operation
  input wire logic                   REG_WR_O,        // Commit pulse
  input wire logic [4:0]             REG_WR_ADDR_O,   // Commit address
  input wire logic [23:0]            STATUS_O         // Status word
);
  logic       cmd_r;
  logic [2:0] ch_r;
  logic [3:0] rate_r;

  // The first byte after a frame start is the command byte
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I)
      cmd_r <= 1'b0;
    else if (TXN_START_I)
      cmd_r <= 1'b1;
    else if (BYTE_VALID_I)
      cmd_r <= 1'b0;
  end

  // Kept so the ready check still knows the channel once the pulse is gone
  always_ff @(posedge CORE_CLK_I) begin
    if (CORE_I.conv_done) begin
      ch_r   <= CORE_I.conv_ch;
      rate_r <= CONV_RATE_O;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  conv_cmd_a: assert property (
    cmd_r && BYTE_VALID_I && !TXN_START_I && BYTE_I[7:6] == 2'h2 |=> CONV_REQ_O
    && CONV_RATE_O == $past(BYTE_I[3:0]) && CONV_MODE_O == $past(BYTE_I[5:4]))
    else $error("conversion command not answered");
  no_start_a: assert property (
    cmd_r && BYTE_VALID_I && !TXN_START_I && !BYTE_I[7] |=> !CONV_REQ_O)
    else $error("command without start bit obeyed");
  busy_pwr_a: assert property (
    1'b1 |=> STATUS_O[3:1] == $past({CORE_I.pwr_state, CORE_I.mod_busy}))
    else $error("busy or power field wrong");
  ref_seen_a: assert property (
    1'b1 |=> STATUS_O[ST_REF] == $past(CORE_I.ref_ok && CORE_I.pwr_state == PWR_CONV))
    else $error("reference flag wrong");
  level_flags_a: assert property (
    1'b1 |=> {STATUS_O[23:22], STATUS_O[11], STATUS_O[9:8]} == {1'b0,
    $past(CORE_I.in_reset), $past(CORE_I.cfg_bad), $past(CORE_I.dout_over),
    $past(CORE_I.ain_over)})
    else $error("level flags wrong");
  ready_set_a: assert property (
    CORE_I.conv_done && CORE_I.conv_ch < 3'h6 ##1 !CORE_I.conv_done |-> ##[0:1]
    (STATUS_O[ST_RDY] && STATUS_O[ST_SRDY_L + ch_r] && STATUS_O[7:4] == rate_r))
    else $error("ready flags not set");
  rd_answer_a: assert property (
    RD_BYTE_VALID_O |-> $past(RD_BYTE_REQ_I))
    else $error("read byte without request");
  wr_target_a: assert property (
    REG_WR_O |-> REG_WR_ADDR_O inside {[5'h01:5'h0b], 5'h0d})
    else $error("write committed to read-only place");
endmodule

`default_nettype wire

/* bench/adcsc_host.sv */
`timescale 1ns/10ps
`default_nettype none

// Byte-level model of the bus host; all changes land on the falling edge
module adcsc_host (
  input  wire logic       clk_i,   // Clock
  input  wire logic [7:0] rdb_i,   // Read byte
  input  wire logic       vld_i,   // Read byte valid
  output var  logic       txn_o,   // Frame start
  output var  logic       bv_o,    // Byte strobe
  output var  logic [7:0] byte_o,  // Written byte
  output var  logic       rq_o     // Read pull
);
  initial begin
    txn_o  = 1'b0;
    bv_o   = 1'b0;
    byte_o = 8'h00;
    rq_o   = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    @(negedge clk_i);
    txn_o  = 1'b0;
    bv_o   = 1'b1;
    byte_o = b;
  endtask

  // Released data shows the inverse, so a stale byte can never pass
  task automatic done();
    @(negedge clk_i);
    bv_o   = 1'b0;
    byte_o = ~byte_o;
  endtask

  // Start pulse, then one command byte, sent as given
  task automatic cmd(input logic [7:0] b);
    @(negedge clk_i);
    txn_o = 1'b1;
    put(b);
  endtask

  task automatic conv(input logic [1:0] m, input logic [3:0] r);
    cmd({2'h2, m, r});  // Bit six low for conversions
    done();
  endtask

  task automatic wr(input logic [4:0] a, input int n, input logic [23:0] d);
    cmd({2'h3, a, 1'b0});
    for (int i = n - 1; i >= 0; i--) put(d[8*i +: 8]);
    done();
  endtask

  // One pull per byte; the answer is taken a cycle later, MSB first
  task automatic rd(input logic [4:0] a, input int n, output logic [23:0] d);
    d = 24'h000000;
    cmd({2'h3, a, 1'b1});
    done();
    for (int i = 0; i < n; i++) begin
      rq_o = 1'b1;
      @(negedge clk_i);
      rq_o = 1'b0;
      d = {d[15:0], vld_i ? rdb_i : 8'hxx};
      @(negedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

/* bench/tb_adc_status_and_command_decode.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_adc_status_and_command_decode;
  import adcsc_pkg::*;

  logic        clk, rst_n, txn, bv, rq, rd_vld, conv_req, reg_wr;
  logic [7:0]  byt, rd_byte;
  logic [3:0]  conv_rate;
  logic [1:0]  conv_mode;
  logic [4:0]  wr_addr;
  logic [23:0] wr_data, status;
  adcsc_core_s core;
  int          failures, cmp_count;

  adcsc_top i_adcsc_top (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .TXN_START_I(txn), .BYTE_VALID_I(bv),
    .BYTE_I(byt), .RD_BYTE_REQ_I(rq), .CORE_I(core), .RD_BYTE_O(rd_byte),
    .RD_BYTE_VALID_O(rd_vld), .CONV_REQ_O(conv_req), .CONV_RATE_O(conv_rate),
    .CONV_MODE_O(conv_mode), .REG_WR_O(reg_wr), .REG_WR_ADDR_O(wr_addr),
    .REG_WR_DATA_O(wr_data), .STATUS_O(status));
  adcsc_host i_adcsc_host (.clk_i(clk), .rdb_i(rd_byte), .vld_i(rd_vld),
    .txn_o(txn), .bv_o(bv), .byte_o(byt), .rq_o(rq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Status is registered; two edges leave margin for derived flags
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic t_regs();
    logic [4:0]  a[3] = '{ADDR_CONTROL_ONE, ADDR_DELAY, ADDR_SOCAL};
    logic [4:0]  r[3] = '{ADDR_STATUS, ADDR_HOLE, ADDR_RESULT_WORD_0};
    logic [23:0] v[3] = '{24'h00005a, 24'h00a55a, 24'h123456};
    logic [23:0] d;
    i_adcsc_host.rd(ADDR_SCGCAL, 3, d);
    chk(d, 24'h000000);
    for (int i = 0; i < 3; i++) begin
      i_adcsc_host.wr(a[i], i + 1, v[i]);
      chk({reg_wr, wr_addr, wr_data}, {1'b1, a[i], v[i]});
      i_adcsc_host.rd(a[i], i + 1, d);
      chk(d, v[i]);
      i_adcsc_host.wr(r[i], 3, 24'hffffff);
      chk(reg_wr, 1'b0);
    end
    i_adcsc_host.rd(ADDR_HOLE, 3, d);
    chk(d, 24'h000000);
    i_adcsc_host.rd(ADDR_RESULT_WORD_0, 3, d);
    chk(d, core.result[0]);
    i_adcsc_host.cmd(8'h35);
    i_adcsc_host.done();
    chk(conv_req, 1'b0);
  endtask

  task automatic t_conv();
    logic [23:0] d;
    for (int m = 0; m < 4; m++) begin
      i_adcsc_host.conv(m[1:0], 4'(m + 5));
      chk({conv_req, conv_mode, conv_rate}, {1'b1, m[1:0], 4'(m + 5)});
    end
    core.conv_ch   = 3'h5;
    core.conv_done = 1'b1;
    @(negedge clk);
    core.conv_done = 1'b0;
    settle();
    chk({status[21], status[7:4], status[0]}, 6'h31);
    i_adcsc_host.rd(ADDR_STATUS, 3, d);
    chk({d[21], d[0]}, 2'h3);
    settle();
    chk({status[21], status[0]}, 2'h0);
  endtask

  task automatic t_levels();
    for (int p = 0; p < 3; p++) begin
      core.pwr_state = p[1:0];
      core.ref_ok    = 1'b1;
      core.mod_busy  = p[0];
      settle();
      chk({status[14], status[3:1]}, {p == 0, p[1:0], p[0]});
    end
    core.pwr_state = PWR_CONV;
    {core.ain_over, core.dout_over, core.cfg_bad, core.in_reset} = 4'hf;
    settle();
    chk({status[23:22], status[11], status[9:8]}, 5'h0f);
    {core.ain_over, core.dout_over, core.cfg_bad, core.in_reset} = 4'h0;
    settle();
    chk({status[23:22], status[11], status[9:8]}, 5'h00);
  endtask

  task automatic t_faults();
    logic [23:0] map[6] = '{24'h002818, 24'h001818, 24'h000078, 24'h000008,
                            24'h002919, 24'h002b19};
    logic [1:0]  ex[6] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0};
    logic [23:0] sm[4] = '{24'h002b19, 24'h002b19, 24'h000000, 24'h000000};
    logic [1:0]  sq[4] = '{MODE_SEQ, MODE_CAL, MODE_SEQ, MODE_CAL};
    logic [3:0]  sf = 4'h6;
    for (int i = 0; i < 6; i++) begin
      i_adcsc_host.wr(ADDR_CMAP_L, 3, map[i]);
      settle();
      chk(status[13:12], ex[i]);
    end
    i_adcsc_host.wr(ADDR_SGCAL, 3, 24'h800000);
    settle();
    chk(status[10], 1'b1);
    i_adcsc_host.wr(ADDR_SGCAL, 3, 24'h7fffff);
    settle();
    chk(status[10], 1'b0);
    for (int i = 0; i < 4; i++) begin
      i_adcsc_host.wr(ADDR_SEQCFG, 1, (i == 1) ? 24'h000004 : 24'h000000);
      i_adcsc_host.wr(ADDR_CMAP_L, 3, sm[i]);
      i_adcsc_host.conv(sq[i], 4'h1);
      settle();
      chk(status[15], sf[i]);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Reset for six cycles, then each scenario in turn
  initial begin
    rst_n       = 1'b0;
    failures    = 0;
    cmp_count   = 0;
    core        = '0;
    core.result = {24'h2468ac, 24'h9abcde, 24'h112233, 24'h13579b};
    // Count rising edges: the first clock assignment can look like a falling edge
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    $display("t_regs done");
    t_conv();
    $display("t_conv done");
    t_levels();
    $display("t_levels done");
    t_faults();
    $display("t_faults done");
    final_report();
  end

  // The scenarios need well under a thousand cycles
  initial begin
    #(25 * 20000);
    failures++;
    final_report();
  end
endmodule

bind adcsc_top adcsc_checker i_adcsc_checker (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .TXN_START_I(TXN_START_I),
  .BYTE_VALID_I(BYTE_VALID_I), .BYTE_I(BYTE_I), .RD_BYTE_REQ_I(RD_BYTE_REQ_I),
  .CORE_I(CORE_I), .RD_BYTE_VALID_O(RD_BYTE_VALID_O), .CONV_REQ_O(CONV_REQ_O),
  .CONV_RATE_O(CONV_RATE_O), .CONV_MODE_O(CONV_MODE_O), .REG_WR_O(REG_WR_O),
  .REG_WR_ADDR_O(REG_WR_ADDR_O), .STATUS_O(STATUS_O));

`default_nettype wire
